// >>> dv/afs_flags_test.sv
// self-checking bench for the alert and fault flag registers
`timescale 1ns/100ps
`default_nettype none
module afs_flags_test;
  logic        clk_in;
  logic        reset_n_in;
  logic [11:0] c;
  logic        wr_en;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, af, ff, d;
  logic        alert_out, fault_out;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [11:0] cv [11] = '{12'h001, 12'h002, 12'h004, 12'h030, 12'h0C0, 12'h010,
                           12'h040, 12'h100, 12'h200, 12'h400, 12'h800};
  logic [7:0]  ev [11] = '{8'h40, 8'h20, 8'h08, 8'h01, 8'h02, 8'h00,
                           8'h00, 8'h20, 8'h04, 8'h01, 8'h02};
  afs_host h (.clk_in(clk_in), .rd_data_in(rd_data), .wr_en_out(wr_en),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .rd_addr_out(rd_addr));
  afs_flags dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en),
    .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_addr_in(rd_addr),
    .cfg_invalid_in(c[0]), .otp_double_err_in(c[1]), .thermal_shutdown_in(c[2]),
    .sleep_ctrl_in(c[3]), .temp_input_one_over_in(c[4]), .temp_input_one_en_in(c[5]),
    .temp_input_two_over_in(c[6]), .temp_input_two_en_in(c[7]),
    .consistency_fail_in(c[8]), .crc_error_in(c[9]), .cell_over_in(c[10]),
    .cell_under_in(c[11]), .rd_data_out(rd_data), .alert_source_flags_out(af),
    .fault_source_flags_out(ff), .alert_out(alert_out), .fault_out(fault_out));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read back, then compare register port and pin
  task automatic look(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d);
    chk("rd_data", e, d);
    chk("flags", e, (a == 8'h20) ? af : ff);
    chk("pin", {7'h00, e != 8'h00}, {7'h00, (a == 8'h20) ? alert_out : fault_out});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_in);
    bad_count++;
    complete_run;
  end
  initial begin
    c = 12'h000;
    reset_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    look(8'h20, 8'h00);
    look(8'h21, 8'h08);
    h.wr(8'h21, 8'h08);
    look(8'h21, 8'h00);
    for (int i = 0; i < 11; i++) begin
      c = cv[i];
      @(negedge clk_in);
      // source held over one rising edge, then released
      c = 12'h000;
      look(i < 7 ? 8'h20 : 8'h21, ev[i]);
      h.wr(i < 7 ? 8'h20 : 8'h21, 8'h00);
      look(i < 7 ? 8'h20 : 8'h21, ev[i]);
      h.wr(i < 7 ? 8'h20 : 8'h21, ev[i]);
      look(i < 7 ? 8'h20 : 8'h21, 8'h00);
    end
    c = 12'h008;
    look(8'h20, 8'h04);
    h.wr(8'h20, 8'h04);
    look(8'h20, 8'h00);
    c = 12'hC00;
    h.wr(8'h21, 8'h03);
    look(8'h21, 8'h03);
    c = 12'h000;
    h.wr(8'h21, 8'h03);
    look(8'h21, 8'h00);
    h.wr(8'h20, 8'h10);
    look(8'h20, 8'h10);
    h.wr(8'h20, 8'h00);
    look(8'h20, 8'h00);
    h.wr(8'h21, 8'hFF);
    look(8'h21, 8'h10);
    h.wr(8'h21, 8'h00);
    look(8'h21, 8'h00);
    h.wr(8'h22, 8'hFF);
    look(8'h20, 8'h00);
    look(8'h21, 8'h00);
    h.rd(8'h22, d);
    chk("unmapped", 8'h00, d);
    complete_run;
  end
endmodule
`default_nettype wire

// >>> dv/afs_host.sv
// host controller model: flag register writes and registered reads
`timescale 1ns/100ps
`default_nettype none
module afs_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  output logic            wr_en_out,
  output logic [7:0]      wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic [7:0]      rd_addr_out
);
  initial begin
    wr_en_out = 1'b0;
    wr_addr_out = 8'h00;
    wr_data_out = 8'h00;
    rd_addr_out = 8'h00;
  end
  // *****
  // bus cycles, entered just after a falling edge
  // *****
  // flags cleared by one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en_out = 1'b1;
    wr_addr_out = a;
    wr_data_out = d;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    // released data shows garbage, not the old byte
    wr_data_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    rd_addr_out = a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// >>> rtl/afs_flags.sv
// module: alert and fault source flag registers with force bits
//
// Operation
// RULE1 - config-integrity flag bit 6 set while protected group invalid, else zero; here it stays set until written one
// RULE2 - host restores protected config registers when integrity flag reads one
// RULE3 - memory-error bit 5 set on uncorrectable double-bit error only
// RULE4 - alert force bit 4 drives alert output; resets to zero
// RULE5 - thermal shutdown active reported at alert bit 3; resets zero
// RULE6 - sleep flag bit 2 set only on entry into sleep
// RULE7 - bit 1 set when input two over threshold and enabled
// RULE8 - bit 0 set when input one over threshold and enabled
// RULE9 - fault register at 0x21; bits 7 and 6 read zero
// RULE10 - fault flags clear only by writing one; zero leaves them
// RULE11 - bit 4 of each register is plain read-write
// RULE12 - internal-consistency fault bit 5 set on check failure
// RULE13 - alert flags clear only by writing one, except force bit
// RULE14 - fault force bit 4 drives fault output; resets zero
// RULE15 - fault bit 2 set on packet crc error
// RULE16 - fault bit 0 on overvoltage, bit 1 on undervoltage
// RULE17 - outputs active when any flag or force bit set
// RULE18 - flags sticky; clear write ignored while condition present
`timescale 1ns/100ps
`default_nettype none
module afs_flags (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [7:0] rd_addr_in,
  input  wire logic       cfg_invalid_in,
  input  wire logic       otp_double_err_in,
  input  wire logic       thermal_shutdown_in,
  input  wire logic       sleep_ctrl_in,
  input  wire logic       temp_input_one_over_in,
  input  wire logic       temp_input_one_en_in,
  input  wire logic       temp_input_two_over_in,
  input  wire logic       temp_input_two_en_in,
  input  wire logic       consistency_fail_in,
  input  wire logic       crc_error_in,
  input  wire logic       cell_over_in,
  input  wire logic       cell_under_in,
  output logic [7:0]      rd_data_out,
  output logic [7:0]      alert_source_flags_out,
  output logic [7:0]      fault_source_flags_out,
  output logic            alert_out,
  output logic            fault_out
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [7:0] alert_flags;
    logic [7:0] fault_flags;
    logic       sleep_prev;
    logic [7:0] rd_data;
    logic       alert;
    logic       fault;
  } afs_state_type;

  afs_state_type st;
  afs_state_type next_st;

  // write-one-to-clear, set wins over clear, force bit is plain read-write
  function automatic logic [7:0] afs_update(input logic [7:0] cur,
                                            input logic [7:0] cond,
                                            input logic       hit,
                                            input logic [7:0] wdata,
                                            input logic [7:0] w1c);
    logic [7:0] res;
    res = cur;
    if (hit) begin
      res = (res & ~(wdata & w1c));
      res = (res & ~afs_pkg::FORCE_MASK) | (wdata & afs_pkg::FORCE_MASK);
    end
    res = res | (cond & w1c);
    return res;
  endfunction

  logic [7:0] alert_cond;
  logic [7:0] fault_cond;
  logic       alert_hit;
  logic       fault_hit;

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb begin
    alert_cond = afs_pkg::ZERO_BYTE;
    fault_cond = afs_pkg::ZERO_BYTE;
    // RULE1 config integrity source
    alert_cond[afs_pkg::BIT_CFG]    = cfg_invalid_in;
    // RULE3 double-bit error only
    alert_cond[afs_pkg::BIT_ECC]    = otp_double_err_in;
    // RULE5 thermal shutdown source
    alert_cond[afs_pkg::BIT_THERMAL]  = thermal_shutdown_in;
    // RULE6 sleep entry edge only
    alert_cond[afs_pkg::BIT_SLEEP]    = sleep_ctrl_in & ~st.sleep_prev;
    // RULE7 gated by enable
    alert_cond[afs_pkg::BIT_TEMP_TWO] = temp_input_two_over_in & temp_input_two_en_in;
    // RULE8 gated by enable
    alert_cond[afs_pkg::BIT_TEMP_ONE] = temp_input_one_over_in & temp_input_one_en_in;
    // RULE12 consistency failure
    fault_cond[afs_pkg::BIT_IFAULT] = consistency_fail_in;
    // RULE15 packet crc error
    fault_cond[afs_pkg::BIT_CRC]    = crc_error_in;
    // RULE16 cell over/under voltage
    fault_cond[afs_pkg::BIT_CELL_HI] = cell_over_in;
    fault_cond[afs_pkg::BIT_CELL_LO] = cell_under_in;
    alert_hit = wr_en_in && (wr_addr_in == afs_pkg::ALERT_SOURCE_FLAGS_ADDR);
    fault_hit = wr_en_in && (wr_addr_in == afs_pkg::FAULT_SOURCE_FLAGS_ADDR);

    next_st = st;
    next_st.sleep_prev = sleep_ctrl_in;
    // RULE13 alert write-one-clear, RULE18 sticky with set priority
    next_st.alert_flags = afs_update(st.alert_flags, alert_cond, alert_hit,
                                     wr_data_in, afs_pkg::ALERT_W1C_MASK);
    // RULE10 fault write-one-clear, RULE11 force read-write
    next_st.fault_flags = afs_update(st.fault_flags, fault_cond, fault_hit,
                                     wr_data_in, afs_pkg::FAULT_W1C_MASK);
    // RULE17 outputs from flags and force; RULE4 RULE14 force drive
    next_st.alert = |next_st.alert_flags;
    next_st.fault = |next_st.fault_flags;
    // RULE9 fault register decode; upper bits never set
    if (rd_addr_in == afs_pkg::ALERT_SOURCE_FLAGS_ADDR) begin
      next_st.rd_data = next_st.alert_flags;
    end else if (rd_addr_in == afs_pkg::FAULT_SOURCE_FLAGS_ADDR) begin
      next_st.rd_data = next_st.fault_flags;
    end else begin
      next_st.rd_data = afs_pkg::ZERO_BYTE;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st.alert_flags <= afs_pkg::ALERT_RESET;
      st.fault_flags <= afs_pkg::FAULT_RESET;
      // assume awake at reset so sleep at power-up still flags
      st.sleep_prev  <= 1'b0;
      st.rd_data     <= afs_pkg::ZERO_BYTE;
      st.alert       <= |afs_pkg::ALERT_RESET;
      st.fault       <= |afs_pkg::FAULT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out            = st.rd_data;
  assign alert_source_flags_out = st.alert_flags;
  assign fault_source_flags_out = st.fault_flags;
  assign alert_out              = st.alert;
  assign fault_out              = st.fault;

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_cfg_set;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_invalid_in |=> alert_source_flags_out[afs_pkg::BIT_CFG];
  endproperty
  a_cfg_set: assert property (p_cfg_set) else $error("config flag not set"); // RULE1

  property p_ecc_set;
    @(posedge clk_in) disable iff (!reset_n_in)
      otp_double_err_in |=> alert_source_flags_out[afs_pkg::BIT_ECC];
  endproperty
  a_ecc_set: assert property (p_ecc_set) else $error("memory error flag not set"); // RULE3

  property p_alert_force;
    @(posedge clk_in) disable iff (!reset_n_in)
      alert_source_flags_out[afs_pkg::BIT_FORCE] |-> alert_out;
  endproperty
  a_alert_force: assert property (p_alert_force) else $error("force not driving alert"); // RULE4

  property p_thermal;
    @(posedge clk_in) disable iff (!reset_n_in)
      thermal_shutdown_in |=> alert_source_flags_out[afs_pkg::BIT_THERMAL] && alert_out;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal flag missing"); // RULE5

  sequence s_sleep_held;
    sleep_ctrl_in [*2];
  endsequence
  property p_sleep_once;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_sleep_held ##0 (alert_hit && wr_data_in[afs_pkg::BIT_SLEEP])
      |=> !alert_source_flags_out[afs_pkg::BIT_SLEEP];
  endproperty
  a_sleep_once: assert property (p_sleep_once) else $error("sleep flag re-set while held"); // RULE6

  property p_temp_two_gate;
    @(posedge clk_in) disable iff (!reset_n_in)
      (temp_input_two_over_in && temp_input_two_en_in)
      |=> alert_source_flags_out[afs_pkg::BIT_TEMP_TWO];
  endproperty
  a_temp_two_gate: assert property (p_temp_two_gate) else $error("input two flag not set"); // RULE7

  // a clear flag stays clear while its input is cool or disabled
  property p_temp_one_gate;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!alert_source_flags_out[afs_pkg::BIT_TEMP_ONE]
       && !(temp_input_one_over_in && temp_input_one_en_in))
      |=> !alert_source_flags_out[afs_pkg::BIT_TEMP_ONE];
  endproperty
  a_temp_one_gate: assert property (p_temp_one_gate) else $error("input one flag set"); // RULE8

  property p_fault_upper;
    @(posedge clk_in) disable iff (!reset_n_in)
      fault_source_flags_out[7:6] == 2'b00;
  endproperty
  a_fault_upper: assert property (p_fault_upper) else $error("unimplemented bits set"); // RULE9

  property p_fault_zero_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      (fault_hit && wr_data_in == afs_pkg::ZERO_BYTE
       && fault_source_flags_out[afs_pkg::BIT_CELL_HI])
      |=> fault_source_flags_out[afs_pkg::BIT_CELL_HI];
  endproperty
  a_fault_zero_write: assert property (p_fault_zero_write) else $error("0 write cleared"); // RULE10

  property p_fault_force;
    @(posedge clk_in) disable iff (!reset_n_in)
      fault_hit
      |=> (fault_source_flags_out[afs_pkg::BIT_FORCE] == $past(wr_data_in[afs_pkg::BIT_FORCE]))
          && (!fault_source_flags_out[afs_pkg::BIT_FORCE] || fault_out);
  endproperty
  a_fault_force: assert property (p_fault_force) else $error("fault force not plain"); // RULE14

  property p_sticky;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cell_under_in && fault_hit) |=> fault_source_flags_out[afs_pkg::BIT_CELL_LO];
  endproperty
  a_sticky: assert property (p_sticky) else $error("clear won over live condition"); // RULE18
endmodule
`default_nettype wire

// >>> rtl/afs_pkg.sv
// package: register offsets, bit positions and reset values for the alert/fault flags
package afs_pkg;
  localparam logic [7:0] ALERT_SOURCE_FLAGS_ADDR = 8'h20;
  localparam logic [7:0] FAULT_SOURCE_FLAGS_ADDR = 8'h21;
  localparam int BIT_TEMP_ONE = 0;
  localparam int BIT_TEMP_TWO = 1;
  localparam int BIT_SLEEP    = 2;
  localparam int BIT_THERMAL  = 3;
  localparam int BIT_FORCE    = 4;
  localparam int BIT_ECC      = 5;
  localparam int BIT_CFG      = 6;
  localparam int BIT_CELL_HI  = 0;
  localparam int BIT_CELL_LO  = 1;
  localparam int BIT_CRC      = 2;
  localparam int BIT_POR      = 3;
  localparam int BIT_IFAULT   = 5;
  // flag bits cleared by write-one; force bit excluded
  localparam logic [7:0] ALERT_W1C_MASK = 8'h6F;
  localparam logic [7:0] FAULT_W1C_MASK = 8'h2F;
  localparam logic [7:0] FORCE_MASK     = 8'h10;
  localparam logic [7:0] ALERT_RESET    = 8'h00;
  // power-on reset flag is set out of reset
  localparam logic [7:0] FAULT_RESET    = 8'h08;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
endpackage
